// File: src/sbc_defines.svh
// constants for the serial batch command port
`ifndef SBC_DEFINES_SVH
`define SBC_DEFINES_SVH
`define SBC_LINE_MAX   80
`define SBC_FIFO_DEPTH 32
`define SBC_MSG_LAST   9
`define SBC_CH_CR      8'h0d
`define SBC_CH_LF      8'h0a
`define SBC_CH_BS      8'h08
`define SBC_CH_SPACE   8'h20
`define SBC_CH_DEV     8'h44
`define SBC_VAL_RST    32'h0000_0000
`define SBC_CLK_HZ     10_000_000
`define SBC_PROC_MS    5
`define SBC_PROC_CYC   ((`SBC_CLK_HZ / 1000) * `SBC_PROC_MS)
`define SBC_STROBE_MS  25
`endif

// File: src/sbc_pkg.sv
// types for the serial batch command port
package sbc_pkg;
  typedef enum logic [3:0] {
    S_IDLE = 4'h0, S_ADDR = 4'h1, S_LINE = 4'h2, S_SKIP = 4'h3,
    S_TOK  = 4'h4, S_PEEK = 4'h5, S_NUM  = 4'h6, S_ACT  = 4'h7,
    S_SEND = 4'h8
  } sbc_state_t;
  typedef enum logic [3:0] {
    C_NONE       = 4'h0, C_READ_COUNT  = 4'h1, C_READ_RATE  = 4'h2,
    C_READ_TOTAL = 4'h3, C_BATCH_START = 4'h4, C_BATCH_STOP = 4'h5,
    C_COUNTER_KF = 4'h6, C_RATE_KF     = 4'h7, C_PRESET     = 4'h8,
    C_PREWARN    = 4'h9, C_COUNTER_RST = 4'ha, C_TOTAL_RST  = 4'hb,
    C_POINT_FREQ = 4'hc, C_POINT_KF    = 4'hd
  } sbc_cmd_t;
  typedef struct packed {
    logic [31:0] count;
    logic [31:0] rate;
    logic [31:0] total;
  } sbc_meas_t;
  typedef struct packed {
    logic        start;
    logic        stop;
    logic        count_ld;
    logic        out_rst;
    logic        total_ld;
    logic [31:0] val;
  } sbc_act_t;
endpackage : sbc_pkg

// File: src/sbc_port.sv
// command interpreter and transmit fifo of the serial batch port
`timescale 1ns/1ps
`include "sbc_defines.svh"

module sbc_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = `SBC_FIFO_DEPTH
) (
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0]      cnt_reg;
  logic [AW-1:0]    wr_reg;
  logic [AW-1:0]    rd_reg;
  logic             push;
  logic             pop;

  assign in_ready  = cnt_reg != (AW+1)'(DEPTH);
  assign out_valid = cnt_reg != '0;
  assign out_data  = mem[rd_reg];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_reg] <= in_data;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_reg <= '0;
      wr_reg  <= '0;
      rd_reg  <= '0;
    end else begin
      if (push) wr_reg <= AW'(wr_reg + 1'b1);
      if (pop) rd_reg <= AW'(rd_reg + 1'b1);
      cnt_reg <= (AW+1)'(cnt_reg + push - pop);
    end
  end
endmodule : sbc_fifo

// How it works
// - strobe plus 3-bit weighted code requests a value sent on transmit
// - strobe and code lines are active high, low or open means zero
// - activate on D, own unit code, space; reply with unit banner
// - while the line is entered, echo every received character back
// - buffer up to 80 characters, codes separated by spaces
// - backspace before carriage return removes the last buffered character
// - carriage return starts execution; answers go out as a background duty
// - keypad entry or new input data aborts the communication cycle
// - each value is preceded by CR LF, only requested, in request order
// - after all answers the unit goes inactive until selected again
// - at most 5 ms processing per request before its answer starts
// - bare read codes send count, rate, total, k-factors (KC reads point 3 when point_opt is set), preset, prewarn
// - load code, space, number stores preset, prewarn or a k-factor (KC loads point 3 when point_opt is set)
// - start command begins a batch, stop command halts it
// - bare counter reset clears or loads preset by mode, resets output
// - counter reset with number loads the counter, nothing else
// - total reset clears the grand total, or loads the given number
// - F or K with letter A to O reads or loads points 1 to 15
// - request code is latched on the strobe rising edge
// - strobe codes 0..6 select preset to rate as tabled
// - nonzero unit keeps transmit undriven until selected or strobed
module sbc_port #(
  parameter int PROC_CYCLES = `SBC_PROC_CYC
) (
  input  wire logic              clk,
  input  wire logic              rst_n,
  input  wire logic [3:0]        unit_code,
  input  wire logic              point_opt,
  input  wire logic              subtracting_count_mode,
  input  wire logic              keypad_evt,
  input  wire logic              input_evt,
  input  wire logic              rx_valid,
  output logic                   rx_ready,
  input  wire logic [7:0]        rx_data,
  output logic                   tx_valid,
  input  wire logic              tx_ready,
  output logic [7:0]             tx_data,
  output logic                   tx_oe,
  input  wire logic              strobe_pin,
  input  wire logic              request_bit_weight1,
  input  wire logic              request_bit_weight2,
  input  wire logic              request_bit_weight4,
  input  wire sbc_pkg::sbc_meas_t meas,
  output sbc_pkg::sbc_act_t      act,
  output logic [31:0]            preset_value,
  output logic [31:0]            prewarn_value,
  output logic [31:0]            counter_kfactor,
  output logic [31:0]            rate_kfactor,
  input  wire logic [3:0]        point_sel,
  output logic [31:0]            point_freq,
  output logic [31:0]            point_kfactor
);
  sbc_pkg::sbc_state_t state_reg, ret_reg;
  sbc_pkg::sbc_cmd_t   cmd;
  logic [7:0]  line_mem [`SBC_LINE_MAX];
  logic [31:0] freq_mem [16];
  logic [31:0] kf_mem   [16];
  logic [6:0]  len_reg, idx_reg;
  logic [7:0]  c1_reg, c2_reg, addr_reg, ch, ch_nx, snd_char;
  logic [1:0]  tok_reg;
  logic        num_reg, online_reg, banner_reg, pend_reg;
  logic [31:0] numv_reg, snd_reg, sel_val;
  logic [3:0]  sidx_reg, pidx;
  logic [2:0]  req_s1, req_s2, code_reg;
  logic        strb_s1, strb_s2, strb_s3, strb_rise;
  logic        exec, rx_fire, abort, f_in_valid, f_in_ready, push, is_rd;
  logic [7:0]  f_in_data;
  logic [16:0] proc_reg;

  function automatic logic is_dig(input logic [7:0] c);
    return c >= 8'h30 && c <= 8'h39;
  endfunction : is_dig

  // 2-ff synchronisers; high level means asserted or one
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      strb_s1 <= 1'b0;
      strb_s2 <= 1'b0;
      strb_s3 <= 1'b0;
      req_s1  <= 3'h0;
      req_s2  <= 3'h0;
    end else begin
      strb_s1 <= strobe_pin;
      strb_s2 <= strb_s1;
      strb_s3 <= strb_s2;
      req_s1  <= {request_bit_weight4, request_bit_weight2,
                  request_bit_weight1};
      req_s2  <= req_s1;
    end
  end
  assign strb_rise = strb_s2 && !strb_s3;

  // strobe request latch; a new edge wins over the pending clear
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      code_reg <= 3'h0;
      pend_reg <= 1'b0;
    end else if (strb_rise) begin
      code_reg <= req_s2;
      pend_reg <= 1'b1;
    end else if (state_reg == sbc_pkg::S_IDLE) begin
      pend_reg <= 1'b0;
    end
  end

  // command decode of the current two-letter token
  always_comb begin
    cmd = sbc_pkg::C_NONE;
    if (tok_reg == 2'd2) begin
      if (c1_reg == 8'h46 && c2_reg >= 8'h41 && c2_reg <= 8'h4f)
        cmd = sbc_pkg::C_POINT_FREQ;
      else if (point_opt && c1_reg == 8'h4b && c2_reg >= 8'h41
               && c2_reg <= 8'h4f)
        cmd = sbc_pkg::C_POINT_KF;
      else begin
        case ({c1_reg, c2_reg})
          16'h4443: cmd = sbc_pkg::C_READ_COUNT;
          16'h4452: cmd = sbc_pkg::C_READ_RATE;
          16'h4454: cmd = sbc_pkg::C_READ_TOTAL;
          16'h474f: cmd = sbc_pkg::C_BATCH_START;
          16'h5354: cmd = sbc_pkg::C_BATCH_STOP;
          16'h4b43: cmd = sbc_pkg::C_COUNTER_KF;
          16'h4b52: cmd = sbc_pkg::C_RATE_KF;
          16'h5041: cmd = sbc_pkg::C_PRESET;
          16'h5057: cmd = sbc_pkg::C_PREWARN;
          16'h5243: cmd = sbc_pkg::C_COUNTER_RST;
          16'h5254: cmd = sbc_pkg::C_TOTAL_RST;
          default:  cmd = sbc_pkg::C_NONE;
        endcase
      end
    end
  end
  assign pidx  = 4'(c2_reg - 8'h41);
  assign is_rd = !num_reg && cmd != sbc_pkg::C_NONE
                 && cmd != sbc_pkg::C_BATCH_START
                 && cmd != sbc_pkg::C_BATCH_STOP
                 && cmd != sbc_pkg::C_COUNTER_RST
                 && cmd != sbc_pkg::C_TOTAL_RST;

  // value chosen by a read token
  always_comb begin
    case (cmd)
      sbc_pkg::C_READ_COUNT: sel_val = meas.count;
      sbc_pkg::C_READ_RATE:  sel_val = meas.rate;
      sbc_pkg::C_READ_TOTAL: sel_val = meas.total;
      sbc_pkg::C_COUNTER_KF: sel_val = counter_kfactor;
      sbc_pkg::C_RATE_KF:    sel_val = rate_kfactor;
      sbc_pkg::C_PRESET:     sel_val = preset_value;
      sbc_pkg::C_PREWARN:    sel_val = prewarn_value;
      sbc_pkg::C_POINT_FREQ: sel_val = freq_mem[pidx];
      sbc_pkg::C_POINT_KF:   sel_val = kf_mem[pidx];
      default:               sel_val = `SBC_VAL_RST;
    endcase
  end

  assign ch    = (idx_reg < len_reg) ? line_mem[idx_reg] : `SBC_CH_SPACE;
  assign ch_nx = (7'(idx_reg + 7'h1) < len_reg) ?
                 line_mem[7'(idx_reg + 7'h1)] : `SBC_CH_SPACE;
  assign exec  = state_reg >= sbc_pkg::S_SKIP;
  assign rx_ready = state_reg == sbc_pkg::S_IDLE
                 || state_reg == sbc_pkg::S_ADDR
                 || (state_reg == sbc_pkg::S_LINE && f_in_ready) || exec;
  assign rx_fire = rx_valid && rx_ready;
  assign abort   = keypad_evt || input_evt || (exec && rx_fire);

  // characters of the banner or of a value answer
  always_comb begin
    case (sidx_reg)
      4'h0: snd_char = banner_reg ? 8'h44 : `SBC_CH_CR;
      4'h1: snd_char = banner_reg ? 8'h65 : `SBC_CH_LF;
      4'h2: snd_char = banner_reg ? 8'h76 : {4'h3, snd_reg[31:28]};
      4'h3: snd_char = banner_reg ? 8'h69 : {4'h3, snd_reg[31:28]};
      4'h4: snd_char = banner_reg ? 8'h63 : {4'h3, snd_reg[31:28]};
      4'h5: snd_char = banner_reg ? 8'h65 : {4'h3, snd_reg[31:28]};
      4'h6: snd_char = banner_reg ? 8'h20 : {4'h3, snd_reg[31:28]};
      4'h7: snd_char = banner_reg ? 8'h23 : {4'h3, snd_reg[31:28]};
      4'h8: snd_char = banner_reg ? ((unit_code > 4'h9) ? 8'h31 : 8'h30)
                                  : {4'h3, snd_reg[31:28]};
      default: snd_char = banner_reg ?
                 {4'h3, (unit_code > 4'h9) ? 4'(unit_code - 4'ha)
                                            : unit_code}
                 : {4'h3, snd_reg[31:28]};
    endcase
  end

  assign f_in_valid = (state_reg == sbc_pkg::S_LINE && rx_valid)
                   || state_reg == sbc_pkg::S_SEND;
  assign f_in_data  = (state_reg == sbc_pkg::S_LINE) ? rx_data : snd_char;
  assign push       = f_in_valid && f_in_ready;

  // line buffer with backspace editing
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      len_reg <= 7'h0;
    end else if (state_reg == sbc_pkg::S_ADDR) begin
      len_reg <= 7'h0;
    end else if (state_reg == sbc_pkg::S_LINE && rx_fire) begin
      if (rx_data == `SBC_CH_BS) begin
        if (len_reg != 7'h0) len_reg <= 7'(len_reg - 7'h1);
      end else if (rx_data != `SBC_CH_CR
                   && len_reg < 7'(`SBC_LINE_MAX)) begin
        len_reg <= 7'(len_reg + 7'h1);
      end
    end
  end

  always_ff @(posedge clk) begin
    if (state_reg == sbc_pkg::S_LINE && rx_fire && rx_data != `SBC_CH_BS
        && rx_data != `SBC_CH_CR && len_reg < 7'(`SBC_LINE_MAX))
      line_mem[len_reg] <= rx_data;
  end

  // main sequencer
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg  <= sbc_pkg::S_IDLE;
      ret_reg    <= sbc_pkg::S_IDLE;
      idx_reg    <= 7'h0;
      c1_reg     <= 8'h00;
      c2_reg     <= 8'h00;
      tok_reg    <= 2'd0;
      num_reg    <= 1'b0;
      numv_reg   <= `SBC_VAL_RST;
      addr_reg   <= 8'h00;
      snd_reg    <= `SBC_VAL_RST;
      sidx_reg   <= 4'h0;
      banner_reg <= 1'b0;
      online_reg <= 1'b0;
    end else if (abort) begin
      state_reg  <= sbc_pkg::S_IDLE;
      online_reg <= 1'b0;
    end else begin
      case (state_reg)
        sbc_pkg::S_IDLE: begin
          online_reg <= 1'b0;
          if (pend_reg) begin
            state_reg  <= sbc_pkg::S_SEND;
            online_reg <= 1'b1;
            banner_reg <= 1'b0;
            sidx_reg   <= 4'h0;
            ret_reg    <= sbc_pkg::S_IDLE;
            case (code_reg)
              3'h0: snd_reg <= preset_value;
              3'h1: snd_reg <= prewarn_value;
              3'h2: snd_reg <= counter_kfactor;
              3'h3: snd_reg <= rate_kfactor;
              3'h4: snd_reg <= meas.count;
              3'h5: snd_reg <= meas.total;
              3'h6: snd_reg <= meas.rate;
              default: state_reg <= sbc_pkg::S_IDLE;
            endcase
          end else if (rx_fire && rx_data == `SBC_CH_DEV) begin
            state_reg <= sbc_pkg::S_ADDR;
            addr_reg  <= 8'hff;
          end
        end
        sbc_pkg::S_ADDR: if (rx_fire) begin
          if (is_dig(rx_data)) begin
            addr_reg <= (addr_reg == 8'hff) ? {4'h0, rx_data[3:0]} :
              (addr_reg < 8'h10) ? 8'(addr_reg * 8'd10 + rx_data[3:0])
                                 : addr_reg;
          end else if (rx_data == `SBC_CH_SPACE
                       && addr_reg == {4'h0, unit_code}) begin
            state_reg  <= sbc_pkg::S_SEND;
            online_reg <= 1'b1;
            banner_reg <= 1'b1;
            sidx_reg   <= 4'h0;
            ret_reg    <= sbc_pkg::S_LINE;
          end else begin
            state_reg <= sbc_pkg::S_IDLE;
          end
        end
        sbc_pkg::S_LINE: if (rx_fire && rx_data == `SBC_CH_CR) begin
          state_reg <= sbc_pkg::S_SKIP;
          idx_reg   <= 7'h0;
        end
        sbc_pkg::S_SKIP: begin
          if (idx_reg >= len_reg) begin
            state_reg <= sbc_pkg::S_IDLE;
          end else if (ch == `SBC_CH_SPACE) begin
            idx_reg <= 7'(idx_reg + 7'h1);
          end else begin
            c1_reg    <= ch;
            tok_reg   <= 2'd1;
            idx_reg   <= 7'(idx_reg + 7'h1);
            state_reg <= sbc_pkg::S_TOK;
          end
        end
        sbc_pkg::S_TOK: begin
          if (idx_reg >= len_reg || ch == `SBC_CH_SPACE) begin
            state_reg <= sbc_pkg::S_PEEK;
          end else begin
            if (tok_reg == 2'd1) c2_reg <= ch;
            if (tok_reg != 2'd3) tok_reg <= 2'(tok_reg + 2'd1);
            idx_reg <= 7'(idx_reg + 7'h1);
          end
        end
        sbc_pkg::S_PEEK: begin
          num_reg  <= 1'b0;
          numv_reg <= `SBC_VAL_RST;
          if (tok_reg == 2'd2 && ch == `SBC_CH_SPACE && is_dig(ch_nx)) begin
            idx_reg   <= 7'(idx_reg + 7'h1);
            state_reg <= sbc_pkg::S_NUM;
          end else begin
            state_reg <= sbc_pkg::S_ACT;
          end
        end
        sbc_pkg::S_NUM: begin
          if (idx_reg < len_reg && is_dig(ch)) begin
            numv_reg <= {numv_reg[27:0], ch[3:0]};
            num_reg  <= 1'b1;
            idx_reg  <= 7'(idx_reg + 7'h1);
          end else begin
            state_reg <= sbc_pkg::S_ACT;
          end
        end
        sbc_pkg::S_ACT: begin
          if (is_rd) begin
            state_reg  <= sbc_pkg::S_SEND;
            snd_reg    <= sel_val;
            banner_reg <= 1'b0;
            sidx_reg   <= 4'h0;
            ret_reg    <= sbc_pkg::S_SKIP;
          end else begin
            state_reg <= sbc_pkg::S_SKIP;
          end
        end
        sbc_pkg::S_SEND: if (push) begin
          sidx_reg <= 4'(sidx_reg + 4'h1);
          if (!banner_reg && sidx_reg >= 4'h2)
            snd_reg <= {snd_reg[27:0], 4'h0};
          if (sidx_reg == 4'(`SBC_MSG_LAST)) state_reg <= ret_reg;
        end
        default: state_reg <= sbc_pkg::S_IDLE;
      endcase
    end
  end

  // stored parameters and point table
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      preset_value    <= `SBC_VAL_RST;
      prewarn_value   <= `SBC_VAL_RST;
      counter_kfactor <= `SBC_VAL_RST;
      rate_kfactor    <= `SBC_VAL_RST;
    end else if (state_reg == sbc_pkg::S_ACT && num_reg && !abort) begin
      case (cmd)
        sbc_pkg::C_PRESET:     preset_value    <= numv_reg;
        sbc_pkg::C_PREWARN:    prewarn_value   <= numv_reg;
        sbc_pkg::C_COUNTER_KF: counter_kfactor <= numv_reg;
        sbc_pkg::C_RATE_KF:    rate_kfactor    <= numv_reg;
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (state_reg == sbc_pkg::S_ACT && num_reg && !abort) begin
      if (cmd == sbc_pkg::C_POINT_FREQ) freq_mem[pidx] <= numv_reg;
      if (cmd == sbc_pkg::C_POINT_KF) kf_mem[pidx] <= numv_reg;
    end
  end
  assign point_freq    = freq_mem[point_sel];
  assign point_kfactor = kf_mem[point_sel];

  // one-cycle action pulses to the counting logic
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      act <= '0;
    end else begin
      act <= '0;
      if (state_reg == sbc_pkg::S_ACT && !abort) begin
        act.start    <= cmd == sbc_pkg::C_BATCH_START;
        act.stop     <= cmd == sbc_pkg::C_BATCH_STOP;
        act.count_ld <= cmd == sbc_pkg::C_COUNTER_RST;
        act.out_rst  <= cmd == sbc_pkg::C_COUNTER_RST && !num_reg;
        act.total_ld <= cmd == sbc_pkg::C_TOTAL_RST;
        if (num_reg) act.val <= numv_reg;
        else if (cmd == sbc_pkg::C_COUNTER_RST && subtracting_count_mode)
          act.val <= preset_value;
      end
    end
  end

  // cycles spent processing since the last answer
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) proc_reg <= '0;
    else if (exec && state_reg != sbc_pkg::S_SEND)
      proc_reg <= 17'(proc_reg + 1'b1);
    else proc_reg <= '0;
  end

  sbc_fifo #(.WIDTH(8), .DEPTH(`SBC_FIFO_DEPTH)) u_fifo (
    .clk       (clk),
    .rst_n     (rst_n),
    .in_valid  (f_in_valid),
    .in_ready  (f_in_ready),
    .in_data   (f_in_data),
    .out_valid (tx_valid),
    .out_ready (tx_ready),
    .out_data  (tx_data)
  );
  assign tx_oe = unit_code == 4'h0 || online_reg || tx_valid;

  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  sequence seq_select;
    state_reg == sbc_pkg::S_ADDR && rx_fire && rx_data == `SBC_CH_SPACE
      && addr_reg == {4'h0, unit_code} && !abort;
  endsequence
  sequence seq_banner;
    state_reg == sbc_pkg::S_SEND && banner_reg && f_in_data == 8'h44;
  endsequence
  chk_select_banner: assert property (seq_select |=> seq_banner)
    else $error("select did not start banner");
  chk_echo_char: assert property (
    state_reg == sbc_pkg::S_LINE && rx_fire |-> push && f_in_data == rx_data)
    else $error("received character not echoed");
  chk_idle_quiet: assert property (
    state_reg == sbc_pkg::S_IDLE || state_reg == sbc_pkg::S_ADDR
    |-> !f_in_valid)
    else $error("echo while inactive");
  chk_bs_remove: assert property (
    state_reg == sbc_pkg::S_LINE && rx_fire
    && rx_data == `SBC_CH_BS && len_reg != 7'h0
    |=> len_reg == 7'($past(len_reg) - 7'h1))
    else $error("backspace did not shorten line");
  chk_line_limit: assert property (len_reg <= 7'(`SBC_LINE_MAX))
    else $error("line buffer overrun");
  chk_abort_idle: assert property (
    abort |=> state_reg == sbc_pkg::S_IDLE && !online_reg)
    else $error("abort not honoured");
  chk_value_prefix: assert property (
    $rose(state_reg == sbc_pkg::S_SEND) && !banner_reg
    |-> f_in_data == `SBC_CH_CR)
    else $error("value not preceded by CR");
  chk_strobe_latch: assert property (
    strb_rise |=> code_reg == $past(req_s2) && pend_reg)
    else $error("strobe code not latched");
  chk_done_inactive: assert property (
    state_reg == sbc_pkg::S_SKIP && idx_reg >= len_reg && !abort
    |=> state_reg == sbc_pkg::S_IDLE
    ##1 (!online_reg || state_reg == sbc_pkg::S_SEND))
    else $error("unit stayed active after line");
  chk_proc_time: assert property (proc_reg < 17'(PROC_CYCLES))
    else $error("request processing too slow");
  chk_preset_load: assert property (
    state_reg == sbc_pkg::S_ACT && num_reg && cmd == sbc_pkg::C_PRESET
    && !abort |=> preset_value == $past(numv_reg))
    else $error("preset not loaded");
  chk_tx_hiz: assert property (unit_code != 4'h0 && !online_reg
    && !tx_valid |-> !tx_oe)
    else $error("transmit driven while offline");
endmodule : sbc_port

// File: sim/sbc_term.sv
// remote terminal model driving and collecting the serial stream
`timescale 1ns/1ps
module sbc_term (
  input  wire logic       clk,
  output logic            rx_valid,
  input  wire logic       rx_ready,
  output logic [7:0]      rx_data,
  input  wire logic       tx_valid,
  output logic            tx_ready,
  input  wire logic [7:0] tx_data
);
  string got;
  logic  stall;
  initial begin
    rx_valid = 1'b0;
    rx_data  = 8'h00;
    tx_ready = 1'b0;
    stall    = 1'b0;
    got      = "";
  end
  // slow sink: takes a character every other cycle
  always @(posedge clk) begin
    if (tx_valid === 1'b1 && tx_ready === 1'b1)
      got = $sformatf("%s%c", got, tx_data);
    stall    <= ~stall;
    tx_ready <= stall;
  end
  // one character held until taken, then idle line shows its inverse
  task automatic send(input string s);
    for (int i = 0; i < s.len(); i++) begin
      @(posedge clk);
      rx_valid <= 1'b1;
      rx_data  <= s[i];
      do @(posedge clk); while (rx_ready !== 1'b1);
      rx_valid <= 1'b0;
      rx_data  <= ~s[i];
    end
  endtask : send
endmodule : sbc_term

// File: sim/sbc_port_tb.sv
// testbench of the serial batch command port
`timescale 1ns/1ps
module sbc_port_tb;
  typedef struct {
    string       sel;
    string       cmd;
    bit          ab;
    string       ans;
    logic [31:0] pv;
  } sbc_row_t;
  logic               clk, rst_n, keypad_evt, strobe_pin;
  logic               request_bit_weight1, request_bit_weight2;
  logic               request_bit_weight4;
  logic               subtracting_count_mode;
  logic               rx_valid, rx_ready, tx_valid, tx_ready, tx_oe;
  logic [7:0]         rx_data, tx_data;
  logic [31:0]        preset_value;
  sbc_pkg::sbc_meas_t meas;
  sbc_pkg::sbc_act_t  act, cap;
  int                 fail_count, tests_run, cyc;
  sbc_row_t rows[7] = '{
    '{"D3 ", "PA 12 PW 34 PA PW\015", 0, "\015\n00000012\015\n00000034",
      32'h12},
    '{"D3 ", "KC 5 XX KR 7 KC KR\015", 0, "\015\n00000005\015\n00000007",
      32'h12},
    '{"D3 ", "PA 9\0107 DC DT\015", 0, "\015\n00001234\015\n00000099",
      32'h7},
    '{"D4 ", "DC\015", 0, "", 32'h7},
    '{"D3 ", "DR DC\015", 1, "", 32'h7},
    '{"D3 ", "DR\015", 0, "\015\n00000056", 32'h7},
    '{"D3 ", "FC 500 FC\015", 0, "\015\n00000500", 32'h7}};
  sbc_port #(.PROC_CYCLES(200)) dut (
    .clk(clk), .rst_n(rst_n), .unit_code(4'h3), .point_opt(1'b0),
    .subtracting_count_mode(subtracting_count_mode),
    .keypad_evt(keypad_evt),
    .input_evt(1'b0), .rx_valid(rx_valid), .rx_ready(rx_ready),
    .rx_data(rx_data), .tx_valid(tx_valid), .tx_ready(tx_ready),
    .tx_data(tx_data), .tx_oe(tx_oe), .strobe_pin(strobe_pin),
    .request_bit_weight1(request_bit_weight1),
    .request_bit_weight2(request_bit_weight2),
    .request_bit_weight4(request_bit_weight4), .meas(meas), .act(act),
    .preset_value(preset_value), .prewarn_value(), .counter_kfactor(),
    .rate_kfactor(), .point_sel(4'h0), .point_freq(), .point_kfactor());
  sbc_term term (
    .clk(clk), .rx_valid(rx_valid), .rx_ready(rx_ready),
    .rx_data(rx_data), .tx_valid(tx_valid), .tx_ready(tx_ready),
    .tx_data(tx_data));
  task automatic end_sim();
    $display("checks %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : end_sim
  task automatic chks(input string what, input string exp, input string got);
    tests_run++;
    if (exp != got) begin
      fail_count++;
      $display("unexpected %s: expected %s seen %s", what, exp, got);
    end
  endtask : chks
  task automatic chk(input string what, input logic [31:0] exp,
                     input logic [31:0] seen);
    tests_run++;
    if (seen !== exp) begin
      fail_count++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  task automatic run(input string sel, input string cmd, input bit ab);
    int n;
    term.got = "";
    term.send(sel);
    n = 0;
    while (term.got.len() < 10 && n < 500) begin
      @(posedge clk);
      n++;
    end
    term.send(cmd);
    if (ab) begin
      keypad_evt <= 1'b1;
      @(posedge clk);
      keypad_evt <= 1'b0;
    end
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (tx_oe !== 1'b0 && n < 3000);
  endtask : run
  task automatic strobe(input logic [2:0] c, input string e);
    term.got = "";
    request_bit_weight1 <= c[0];
    request_bit_weight2 <= c[1];
    request_bit_weight4 <= c[2];
    repeat (2) @(posedge clk);
    strobe_pin <= 1'b1;
    repeat (30) @(posedge clk);
    strobe_pin <= 1'b0;
    for (int n = 0; n < 500 && term.got.len() < 10; n++)
      @(posedge clk);
    chks("strobe answer", e, term.got);
  endtask : strobe
  always @(posedge clk) if (act.count_ld === 1'b1) cap <= act;
  always @(posedge clk) begin
    cyc++;
    if (cyc == 60000) begin
      fail_count++;
      end_sim();
    end
  end
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  initial begin
    {rst_n, keypad_evt, strobe_pin, subtracting_count_mode, cap} = '0;
    {request_bit_weight1, request_bit_weight2, request_bit_weight4} = '0;
    meas = '{count: 32'h1234, rate: 32'h56, total: 32'h99};
    repeat (5) @(posedge clk);
    chk("tx_oe idle", 32'h0, tx_oe);
    rst_n <= 1'b1;
    foreach (rows[i]) begin
      run(rows[i].sel, rows[i].cmd, rows[i].ab);
      chks("serial reply", (rows[i].sel == "D3 ") ?
           {"Device #03", rows[i].cmd, rows[i].ans} : "", term.got);
      chk("preset", rows[i].pv, preset_value);
    end
    run("D3 ", "RC 5\r", 0);
    chk("count load", 32'h5, cap.val);
    chk("output reset", 32'h0, cap.out_rst);
    subtracting_count_mode <= 1'b1;
    run("D3 ", "RC\015", 0);
    chk("count preset", 32'h7, cap.val);
    chk("bare reset output", 32'h1, cap.out_rst);
    strobe(3'h5, "\015\n00000099");
    meas.count <= 32'h4321;
    strobe(3'h4, "\015\n00004321");
    rst_n <= 1'b0;
    @(posedge clk);
    chk("reset tx_oe", 32'h0, tx_oe);
    chk("reset preset", 32'h0, preset_value);
    end_sim();
  end
endmodule : sbc_port_tb
